// [tx_assembly_event_queue.v]
// Transmit assembly event queue: merges timer, HDLC and software events.
// Assumes producers hold valid until ready; engine drains with ev_ready.
`timescale 1ns/1ps
`default_nettype none
`include "txq_consts.vh"
module tx_assembly_event_queue #(
  parameter DEPTH_LOG2 = 4,
  parameter TDM_W = 16,
  parameter TS_W = 16
) (
  input wire clock,
  input wire rst_n,
  // Service timer producer
  input wire tmr_valid,
  output reg tmr_ready,
  input wire tmr_is_sof,
  input wire tmr_scan_flag,
  input wire tmr_channel_start_flag,
  input wire [14:0] tmr_conn_base,
  // HDLC producer
  input wire hdlc_valid,
  output reg hdlc_ready,
  input wire hdlc_is_aal2,
  input wire [31:0] hdlc_desc,
  input wire [31:0] hdlc_ptrs,
  input wire [11:0] hdlc_stream,
  // Shared context
  input wire [TDM_W-1:0] tdm_write_ptr,
  input wire [TS_W-1:0] bus_timestamp,
  input wire [TS_W-1:0] frame_timestamp,
  // Engine side
  output reg ev_valid,
  input wire ev_ready,
  output reg [2:0] ev_type,
  output reg [14:0] ev_conn_base,
  output reg [16:0] ev_pkt_base,
  output reg [TDM_W-1:0] ev_tdm_ptr,
  output reg [TS_W-1:0] ev_timestamp,
  output reg [3:0] ev_buf_size,
  output reg [10:0] ev_pkt_len,
  output reg [10:0] ev_aal2_li,
  output reg [7:0] ev_cps_timer,
  output reg [6:0] ev_cid,
  output reg [11:0] ev_stream,
  output reg ev_scan_flag,
  output reg ev_channel_start_flag,
  output reg ev_flush_pending_flag,
  output reg ev_timestamp_offset_select,
  output reg [15:0] ev_rtp_seq,
  // AXI4-Lite slave
  input wire [11:0] s_awaddr,
  input wire s_awvalid,
  output reg s_awready,
  input wire [31:0] s_wdata,
  input wire [3:0] s_wstrb,
  input wire s_wvalid,
  output reg s_wready,
  output reg [1:0] s_bresp,
  output reg s_bvalid,
  input wire s_bready,
  input wire [11:0] s_araddr,
  input wire s_arvalid,
  output reg s_arready,
  output reg [31:0] s_rdata,
  output reg [1:0] s_rresp,
  output reg s_rvalid,
  input wire s_rready
);
  // ==========================================================
  // Queue entry layout, bit positions from the bottom
  localparam E_TI = 0;
  localparam E_FL = 1;
  localparam E_ST = 2;
  localparam E_SC = 3;
  localparam E_STREAM = 4;
  localparam E_CID = E_STREAM + 12;
  localparam E_CPS = E_CID + 7;
  localparam E_LEN = E_CPS + 8;
  localparam E_BUF = E_LEN + 11;
  localparam E_TS = E_BUF + 4;
  localparam E_TDM = E_TS + TS_W;
  localparam E_PB = E_TDM + TDM_W;
  localparam E_CB = E_PB + 17;
  localparam E_TYPE = E_CB + 15;
  localparam W = E_TYPE + 3;
  // ==========================================================
  // Software descriptor registers
  reg [31:0] desc0_q;
  reg [31:0] desc1_q;
  reg cpu_aal2_q;
  reg cpu_pend_q;
  reg [15:0] seq_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg aw_have_q;
  reg w_have_q;
  reg [TS_W-1:0] cpu_ts_q;
  wire full;
  wire empty;
  wire [W-1:0] rd_data;
  // ==========================================================
  // Arbiter: timer, then HDLC, then software; each stalls on full
  localparam S_IDLE = 3'b001;
  localparam S_OUT = 3'b010;
  localparam S_LOAD = 3'b100;
  reg [2:0] state_q;
  reg [W-1:0] ent;
  reg wr_en;
  reg take_tmr;
  reg take_hdlc;
  reg take_cpu;
  always @* begin
    ent = {W{1'b0}};
    wr_en = 1'b0;
    take_tmr = 1'b0;
    take_hdlc = 1'b0;
    take_cpu = 1'b0;
    // A ready pulse blocks the next take for one cycle
    if (!full && !tmr_ready && !hdlc_ready) begin
      if (tmr_valid) begin
        take_tmr = 1'b1;
        wr_en = 1'b1;
        ent = {(tmr_is_sof ? `EV_SOF : `EV_VOICE), tmr_conn_base, 17'h00000, tdm_write_ptr,
               frame_timestamp, 4'h0, 11'h000, 8'h00, 7'h00, 12'h000,
               tmr_scan_flag, tmr_channel_start_flag, 1'b0, 1'b0};
      end else if (hdlc_valid) begin
        take_hdlc = 1'b1;
        wr_en = 1'b1;
        ent = {(hdlc_is_aal2 ? `EV_HDLC_AAL2 : `EV_HDLC_RTP), hdlc_ptrs[`F_CB_HI:`F_CB_LO],
               hdlc_ptrs[`F_PB_HI:`F_PB_LO], tdm_write_ptr, frame_timestamp,
               hdlc_desc[`F_BUF_HI:`F_BUF_LO], hdlc_desc[`F_LEN_HI:`F_LEN_LO],
               hdlc_desc[`F_CPS_HI:`F_CPS_LO], 7'h00, hdlc_stream, 1'b0, 1'b0,
               hdlc_desc[`F_FL], hdlc_desc[`F_TI]};
      end else if (cpu_pend_q) begin
        take_cpu = 1'b1;
        wr_en = 1'b1;
        ent = {(cpu_aal2_q ? `EV_CPU_AAL2 : `EV_CPU_RTP), desc1_q[`F_CB_HI:`F_CB_LO],
               desc1_q[`F_PB_HI:`F_PB_LO], tdm_write_ptr, cpu_ts_q,
               desc0_q[`F_BUF_HI:`F_BUF_LO], desc0_q[`F_LEN_HI:`F_LEN_LO],
               desc0_q[`F_CPS_HI:`F_CPS_LO], desc0_q[`F_CID_HI:`F_CID_LO], 12'h000,
               1'b0, 1'b0, desc0_q[`F_FL], desc0_q[`F_TI]};
      end
    end
  end
  // Ready pulses in the cycle that follows the taking edge
  always @(posedge clock) begin
    if (!rst_n) begin
      tmr_ready <= 1'b0;
      hdlc_ready <= 1'b0;
    end else begin
      tmr_ready <= take_tmr;
      hdlc_ready <= take_hdlc;
    end
  end
  // Head entry leaves the store while loading
  wire pop_head = (state_q == S_LOAD);
  event_store #(
    .WIDTH(W),
    .DEPTH_LOG2(DEPTH_LOG2)
  ) u_store (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(wr_en),
    .wr_data(ent),
    .rd_en(pop_head),
    .rd_data(rd_data),
    .full(full),
    .empty(empty)
  );
  // ==========================================================
  // Output stage: one registered event at a time, in arrival order
  wire [2:0] r_type = rd_data[E_TYPE+2:E_TYPE];
  wire [14:0] r_cb = rd_data[E_CB+14:E_CB];
  wire [16:0] r_pb = rd_data[E_PB+16:E_PB];
  wire [TDM_W-1:0] r_tdm = rd_data[E_TDM+TDM_W-1:E_TDM];
  wire [TS_W-1:0] r_ts = rd_data[E_TS+TS_W-1:E_TS];
  wire [3:0] r_buf = rd_data[E_BUF+3:E_BUF];
  wire [10:0] r_len = rd_data[E_LEN+10:E_LEN];
  wire [7:0] r_cps = rd_data[E_CPS+7:E_CPS];
  wire [6:0] r_cid = rd_data[E_CID+6:E_CID];
  wire [11:0] r_stream = rd_data[E_STREAM+11:E_STREAM];
  wire r_scan = rd_data[E_SC];
  wire r_start = rd_data[E_ST];
  wire r_fl = rd_data[E_FL];
  wire r_ti = rd_data[E_TI];
  wire r_rtp = (r_type == `EV_HDLC_RTP) || (r_type == `EV_CPU_RTP);
  wire r_aal2 = (r_type == `EV_HDLC_AAL2) || (r_type == `EV_CPU_AAL2);
  always @(posedge clock) begin
    if (!rst_n) begin
      state_q <= S_IDLE;
      ev_valid <= 1'b0;
      ev_type <= `EV_SOF;
      ev_conn_base <= 15'h0000;
      ev_pkt_base <= 17'h00000;
      ev_tdm_ptr <= {TDM_W{1'b0}};
      ev_timestamp <= {TS_W{1'b0}};
      ev_buf_size <= 4'h0;
      ev_pkt_len <= 11'h000;
      ev_aal2_li <= 11'h000;
      ev_cps_timer <= 8'h00;
      ev_cid <= 7'h00;
      ev_stream <= 12'h000;
      ev_scan_flag <= 1'b0;
      ev_channel_start_flag <= 1'b0;
      ev_flush_pending_flag <= 1'b0;
      ev_timestamp_offset_select <= 1'b0;
      ev_rtp_seq <= 16'h0000;
      seq_q <= 16'h0000;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (!empty) begin
            state_q <= S_LOAD;
          end
        end
        S_LOAD: begin
          // Pop the head entry into the output registers
          state_q <= S_OUT;
          ev_valid <= 1'b1;
          ev_type <= r_type;
          ev_conn_base <= r_cb;
          ev_pkt_base <= r_pb;
          ev_tdm_ptr <= r_tdm;
          // Offset select adds the live bus time at dequeue
          ev_timestamp <= (r_ti && r_rtp) ? r_ts + bus_timestamp : r_ts;
          ev_buf_size <= r_buf;
          ev_pkt_len <= r_len;
          ev_aal2_li <= r_aal2 ? r_len - `AAL2_LI_ADJ : 11'h000;
          ev_cps_timer <= r_cps;
          ev_cid <= r_cid;
          ev_stream <= r_stream;
          ev_scan_flag <= r_scan;
          ev_channel_start_flag <= r_start;
          ev_flush_pending_flag <= r_aal2 & r_fl;
          ev_timestamp_offset_select <= r_rtp & r_ti;
          ev_rtp_seq <= seq_q;
          // Seq counts every RTP event, injected ones too
          if (r_rtp) begin
            seq_q <= seq_q + 16'h0001;
          end
        end
        S_OUT: begin
          if (ev_ready) begin
            ev_valid <= 1'b0;
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
  // ==========================================================
  // AXI4-Lite register slave
  wire do_wr = aw_have_q && w_have_q && !s_bvalid;
  always @(posedge clock) begin
    if (!rst_n) begin
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= `R_OKAY;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h00000000;
      desc0_q <= 32'h00000000;
      desc1_q <= 32'h00000000;
      cpu_aal2_q <= 1'b0;
      cpu_pend_q <= 1'b0;
      cpu_ts_q <= {TS_W{1'b0}};
    end else begin
      s_awready <= !aw_have_q && s_awvalid && !s_awready;
      s_wready <= !w_have_q && s_wvalid && !s_wready;
      if (s_awvalid && s_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_wdata;
      end
      if (take_cpu) begin
        cpu_pend_q <= 1'b0;
      end
      if (do_wr) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= `R_OKAY;
        // Descriptor writes are dropped while one is still queued
        case (awaddr_q)
          `A_DESC0: begin
            if (!cpu_pend_q) desc0_q <= wdata_q;
          end
          `A_DESC1: begin
            if (!cpu_pend_q) desc1_q <= wdata_q;
          end
          `A_CTRL: begin
            // Frame time is captured when the descriptor is queued
            if (wdata_q[`B_GO] && !cpu_pend_q) begin
              cpu_pend_q <= 1'b1;
              cpu_aal2_q <= wdata_q[`B_CLR];
              cpu_ts_q <= frame_timestamp;
            end
          end
          `A_STAT, `A_DESC2, `A_DESC3, `A_SEQ: begin
          end
          default: begin
            s_bresp <= `R_SLVERR;
          end
        endcase
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end
  always @(posedge clock) begin
    if (!rst_n) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h00000000;
      s_rresp <= `R_OKAY;
    end else begin
      s_arready <= s_arvalid && !s_arready && !s_rvalid;
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp <= `R_OKAY;
        // Status reads see the live store flags
        case (s_araddr)
          `A_CTRL: s_rdata <= {31'h00000000, cpu_aal2_q} << `B_CLR;
          `A_STAT: s_rdata <= {29'h00000000, empty, full, cpu_pend_q};
          `A_DESC0: s_rdata <= desc0_q;
          `A_DESC1: s_rdata <= desc1_q;
          `A_DESC2, `A_DESC3: s_rdata <= 32'h00000000;
          `A_SEQ: s_rdata <= {16'h0000, seq_q};
          default: begin
            s_rdata <= 32'h00000000;
            s_rresp <= `R_SLVERR;
          end
        endcase
      end else if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// [txq_consts.vh]
// Constants for the transmit assembly event queue.
// Assumes inclusion by bare name from the queue, its assertions and its bench.
`ifndef TXQ_CONSTS_VH
`define TXQ_CONSTS_VH
`define EV_SOF 3'h0
`define EV_HDLC_RTP 3'h1
`define EV_HDLC_AAL2 3'h2
`define EV_VOICE 3'h3
`define EV_CPU_RTP 3'h4
`define EV_CPU_AAL2 3'h5
`define AAL2_LI_ADJ 11'h002
`define A_CTRL 12'h000
`define A_STAT 12'h004
`define A_DESC0 12'h008
`define A_DESC1 12'h00C
`define A_DESC2 12'h010
`define A_DESC3 12'h014
`define A_SEQ 12'h018
`define R_OKAY 2'h0
`define R_SLVERR 2'h2
`define B_GO 0
`define B_CLR 1
`define B_BUSY 0
`define B_FULL 1
`define B_EMPTY 2
`define F_LEN_LO 0
`define F_LEN_HI 10
`define F_BUF_LO 11
`define F_BUF_HI 14
`define F_TI 15
`define F_FL 16
`define F_CPS_LO 17
`define F_CPS_HI 24
`define F_CID_LO 25
`define F_CID_HI 31
`define F_CB_LO 0
`define F_CB_HI 14
`define F_PB_LO 15
`define F_PB_HI 31
`endif

// [event_store.v]
// Circular event storage with honest full and empty flags.
// Assumes writer checks full and reader checks empty.
`timescale 1ns/1ps
`default_nettype none
module event_store #(
  parameter WIDTH = 128,
  parameter DEPTH_LOG2 = 4
) (
  input wire clock,
  input wire rst_n,
  input wire wr_en,
  input wire [WIDTH-1:0] wr_data,
  input wire rd_en,
  output wire [WIDTH-1:0] rd_data,
  output wire full,
  output wire empty
);
  reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];
  reg [DEPTH_LOG2:0] wp_q;
  reg [DEPTH_LOG2:0] rp_q;
  assign empty = (wp_q == rp_q);
  assign full = (wp_q[DEPTH_LOG2] != rp_q[DEPTH_LOG2]) &&
                (wp_q[DEPTH_LOG2-1:0] == rp_q[DEPTH_LOG2-1:0]);
  assign rd_data = mem[rp_q[DEPTH_LOG2-1:0]];
  always @(posedge clock) begin
    if (wr_en && !full) begin
      mem[wp_q[DEPTH_LOG2-1:0]] <= wr_data;
    end
  end
  always @(posedge clock) begin
    if (!rst_n) begin
      wp_q <= {(DEPTH_LOG2+1){1'b0}};
      rp_q <= {(DEPTH_LOG2+1){1'b0}};
    end else begin
      if (wr_en && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (rd_en && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [txq_sva.sv]
// Port-level assertions for the transmit assembly event queue.
// Assumes the bind below attaches it to every queue instance.
`timescale 1ns/1ps
`default_nettype none
`include "txq_consts.vh"
// ===== Checker
module txq_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic tmr_valid,
  input wire logic tmr_ready,
  input wire logic hdlc_valid,
  input wire logic hdlc_ready,
  input wire logic ev_valid,
  input wire logic ev_ready,
  input wire logic [2:0] ev_type,
  input wire logic [14:0] ev_conn_base,
  input wire logic [10:0] ev_pkt_len,
  input wire logic [10:0] ev_aal2_li,
  input wire logic ev_flush_pending_flag,
  input wire logic ev_timestamp_offset_select,
  input wire logic s_bvalid,
  input wire logic s_bready
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_TMR_ACK: assert property (tmr_ready |-> $past(tmr_valid) ##1 !tmr_ready)
    else $error("timer ready without request");
  AST_HDLC_ACK: assert property (hdlc_ready |-> $past(hdlc_valid) ##1 !hdlc_ready)
    else $error("hdlc ready without request");
  AST_EV_HOLD: assert property (ev_valid && !ev_ready |=> ev_valid && $stable(ev_type) && $stable(ev_conn_base))
    else $error("event changed before taken");
  AST_EV_GAP: assert property (ev_valid && ev_ready |=> !ev_valid)
    else $error("no idle cycle after dequeue");
  AST_LI: assert property (ev_valid && ev_type inside {`EV_HDLC_AAL2, `EV_CPU_AAL2}
    |-> ev_aal2_li == ev_pkt_len - `AAL2_LI_ADJ)
    else $error("length indicator wrong");
  AST_FLUSH: assert property (ev_valid && ev_flush_pending_flag |-> ev_type inside {`EV_HDLC_AAL2, `EV_CPU_AAL2})
    else $error("flush on non aal2 event");
  AST_TI: assert property (ev_valid && ev_timestamp_offset_select |-> ev_type inside {`EV_HDLC_RTP, `EV_CPU_RTP})
    else $error("offset select on non rtp event");
  AST_TYPE: assert property (ev_valid |-> ev_type <= `EV_CPU_AAL2)
    else $error("unknown event type");
  AST_BHOLD: assert property (s_bvalid && !s_bready |=> s_bvalid)
    else $error("write response dropped");
endmodule
bind tx_assembly_event_queue txq_sva txq_sva_i (.clock(clock), .rst_n(rst_n), .tmr_valid(tmr_valid),
  .tmr_ready(tmr_ready), .hdlc_valid(hdlc_valid), .hdlc_ready(hdlc_ready), .ev_valid(ev_valid),
  .ev_ready(ev_ready), .ev_type(ev_type), .ev_conn_base(ev_conn_base), .ev_pkt_len(ev_pkt_len),
  .ev_aal2_li(ev_aal2_li), .ev_flush_pending_flag(ev_flush_pending_flag),
  .ev_timestamp_offset_select(ev_timestamp_offset_select), .s_bvalid(s_bvalid), .s_bready(s_bready));
`default_nettype wire

// [hdlc_source.sv]
// Model of the HDLC engine handing over finished mini-packets.
// Assumes the queue answers with a one-cycle ready pulse.
`timescale 1ns/1ps
`default_nettype none
// ===== HDLC producer
module hdlc_source (
  input wire logic clock,
  input wire logic hdlc_ready,
  output logic hdlc_valid,
  output logic hdlc_is_aal2,
  output logic [31:0] hdlc_desc,
  output logic [31:0] hdlc_ptrs,
  output logic [11:0] hdlc_stream
);
  initial begin
    hdlc_valid = 1'h0;
    hdlc_is_aal2 = 1'h0;
    hdlc_desc = 32'h0;
    hdlc_ptrs = 32'h0;
    hdlc_stream = 12'h0;
  end
  // Hold until taken, then scramble released lines
  task automatic send(input logic a, input logic [31:0] d, input logic [31:0] p, input logic [11:0] s);
    @(posedge clock);
    hdlc_valid <= 1'h1;
    hdlc_is_aal2 <= a;
    hdlc_desc <= d;
    hdlc_ptrs <= p;
    hdlc_stream <= s;
    @(posedge clock);
    while (hdlc_ready !== 1'h1) @(posedge clock);
    hdlc_valid <= 1'h0;
    hdlc_desc <= ~d;
    hdlc_ptrs <= ~p;
    hdlc_stream <= ~s;
  endtask
endmodule
`default_nettype wire

// [tx_assembly_event_queue_tb.sv]
// Self-checking bench for the transmit assembly event queue.
// Assumes a four-entry store and a constant bus timestamp.
`timescale 1ns/1ps
`default_nettype none
`include "txq_consts.vh"
module tx_assembly_event_queue_tb;
  logic clock, rst_n, tmr_valid, tmr_ready, tmr_is_sof, tmr_scan_flag, tmr_channel_start_flag;
  logic hdlc_valid, hdlc_ready, hdlc_is_aal2, ev_valid, ev_ready, ev_scan_flag, ev_channel_start_flag;
  logic ev_flush_pending_flag, ev_timestamp_offset_select;
  logic [14:0] tmr_conn_base, ev_conn_base;
  logic [31:0] hdlc_desc, hdlc_ptrs, s_wdata, s_rdata;
  logic [11:0] hdlc_stream, ev_stream, s_awaddr, s_araddr;
  logic [15:0] tdm_write_ptr, bus_timestamp, frame_timestamp, ev_tdm_ptr, ev_timestamp, ev_rtp_seq;
  logic [2:0] ev_type;
  logic [16:0] ev_pkt_base;
  logic [3:0] ev_buf_size, s_wstrb;
  logic [10:0] ev_pkt_len, ev_aal2_li;
  logic [7:0] ev_cps_timer;
  logic [6:0] ev_cid;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [1:0] s_bresp, s_rresp;
  int mismatches = 0;
  int num_checks = 0;
  int cycles = 0;
  tx_assembly_event_queue #(.DEPTH_LOG2(2)) tx_assembly_event_queue_i (.clock(clock), .rst_n(rst_n),
    .tmr_valid(tmr_valid), .tmr_ready(tmr_ready), .tmr_is_sof(tmr_is_sof), .tmr_scan_flag(tmr_scan_flag),
    .tmr_channel_start_flag(tmr_channel_start_flag), .tmr_conn_base(tmr_conn_base),
    .hdlc_valid(hdlc_valid), .hdlc_ready(hdlc_ready), .hdlc_is_aal2(hdlc_is_aal2), .hdlc_desc(hdlc_desc),
    .hdlc_ptrs(hdlc_ptrs), .hdlc_stream(hdlc_stream), .tdm_write_ptr(tdm_write_ptr),
    .bus_timestamp(bus_timestamp), .frame_timestamp(frame_timestamp), .ev_valid(ev_valid),
    .ev_ready(ev_ready), .ev_type(ev_type), .ev_conn_base(ev_conn_base), .ev_pkt_base(ev_pkt_base),
    .ev_tdm_ptr(ev_tdm_ptr), .ev_timestamp(ev_timestamp), .ev_buf_size(ev_buf_size),
    .ev_pkt_len(ev_pkt_len), .ev_aal2_li(ev_aal2_li), .ev_cps_timer(ev_cps_timer), .ev_cid(ev_cid),
    .ev_stream(ev_stream), .ev_scan_flag(ev_scan_flag), .ev_channel_start_flag(ev_channel_start_flag),
    .ev_flush_pending_flag(ev_flush_pending_flag), .ev_timestamp_offset_select(ev_timestamp_offset_select),
    .ev_rtp_seq(ev_rtp_seq), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready));
  hdlc_source hdlc_source_i (.clock(clock), .hdlc_ready(hdlc_ready), .hdlc_valid(hdlc_valid),
    .hdlc_is_aal2(hdlc_is_aal2), .hdlc_desc(hdlc_desc), .hdlc_ptrs(hdlc_ptrs), .hdlc_stream(hdlc_stream));
  // ===== Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic ctx(input logic [15:0] tp);
    tdm_write_ptr <= tp;
    frame_timestamp <= tp + 16'h0100;
  endtask
  task automatic tmr_push(input logic sof, input logic sc, input logic st, input logic [14:0] cb, input logic [15:0] tp);
    @(posedge clock);
    ctx(tp);
    tmr_valid <= 1'h1;
    tmr_is_sof <= sof;
    tmr_scan_flag <= sc;
    tmr_channel_start_flag <= st;
    tmr_conn_base <= cb;
    @(posedge clock);
    while (tmr_ready !== 1'h1) @(posedge clock);
    tmr_valid <= 1'h0;
    tmr_conn_base <= ~cb;
  endtask
  task automatic pop(input logic [2:0] t, input logic [14:0] cb);
    @(posedge clock);
    while (ev_valid !== 1'h1) @(posedge clock);
    check(ev_type, t);
    check(ev_conn_base, cb);
  endtask
  task automatic take;
    ev_ready <= 1'h1;
    @(posedge clock);
    ev_ready <= 1'h0;
  endtask
  task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clock);
    s_awaddr <= a;
    s_awvalid <= 1'h1;
    s_wdata <= d;
    s_wvalid <= 1'h1;
    s_bready <= 1'h1;
    fork
      begin
        @(posedge clock);
        while (s_awready !== 1'h1) @(posedge clock);
        s_awvalid <= 1'h0;
      end
      begin
        @(posedge clock);
        while (s_wready !== 1'h1) @(posedge clock);
        s_wvalid <= 1'h0;
      end
    join
    while (s_bvalid !== 1'h1) @(posedge clock);
    s_bready <= 1'h0;
    check(s_bresp, er);
  endtask
  task automatic axr(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clock);
    s_araddr <= a;
    s_arvalid <= 1'h1;
    s_rready <= 1'h1;
    @(posedge clock);
    while (s_arready !== 1'h1) @(posedge clock);
    s_arvalid <= 1'h0;
    while (s_rvalid !== 1'h1) @(posedge clock);
    s_rready <= 1'h0;
    check(s_rdata, ed);
    check(s_rresp, er);
  endtask
  // ===== Scenarios
  // Six events overfill the store; none may be lost or reordered
  task automatic order_fields;
    fork
      begin
        tmr_push(1'h1, 1'h1, 1'h0, 15'h0011, 16'h0A00);
        tmr_push(1'h0, 1'h0, 1'h1, 15'h0022, 16'h0A01);
        ctx(16'h0A02);
        hdlc_source_i.send(1'h1, {7'h00, 8'h05, 1'h1, 1'h0, 4'h3, 11'h030}, {17'h00123, 15'h0033}, 12'h044);
        ctx(16'h0A03);
        hdlc_source_i.send(1'h0, {7'h00, 8'h00, 1'h0, 1'h1, 4'h2, 11'h014}, {17'h00456, 15'h0055}, 12'h066);
        tmr_push(1'h0, 1'h0, 1'h0, 15'h0077, 16'h0A04);
        tmr_push(1'h0, 1'h0, 1'h1, 15'h0088, 16'h0A05);
      end
      begin
        repeat (40) @(posedge clock);
        pop(`EV_SOF, 15'h0011);
        check(ev_scan_flag, 1'h1);
        check(ev_tdm_ptr, 16'h0A00);
        take;
        pop(`EV_VOICE, 15'h0022);
        check(ev_channel_start_flag, 1'h1);
        check(ev_timestamp, 16'h0B01);
        take;
        pop(`EV_HDLC_AAL2, 15'h0033);
        check(ev_pkt_len, 11'h030);
        check(ev_buf_size, 4'h3);
        check(ev_aal2_li, 11'h02E);
        check(ev_flush_pending_flag, 1'h1);
        check(ev_cps_timer, 8'h05);
        check(ev_stream, 12'h044);
        check(ev_pkt_base, 17'h00123);
        take;
        pop(`EV_HDLC_RTP, 15'h0055);
        check(ev_timestamp, 16'h1B03);
        check(ev_timestamp_offset_select, 1'h1);
        check(ev_rtp_seq, 16'h0000);
        check(ev_tdm_ptr, 16'h0A03);
        take;
        pop(`EV_VOICE, 15'h0077);
        check(ev_channel_start_flag, 1'h0);
        take;
        pop(`EV_VOICE, 15'h0088);
        take;
      end
    join
  endtask
  // Payload taken as already stored, header included
  task automatic cpu_inject;
    ctx(16'h0C00);
    axw(`A_DESC0, {7'h00, 8'h00, 1'h0, 1'h1, 4'h2, 11'h014}, `R_OKAY);
    axw(`A_DESC1, {17'h00200, 15'h0066}, `R_OKAY);
    axw(`A_CTRL, 32'h1, `R_OKAY);
    pop(`EV_CPU_RTP, 15'h0066);
    check(ev_rtp_seq, 16'h0001);
    check(ev_pkt_base, 17'h00200);
    check(ev_timestamp, 16'h1D00);
    check(ev_timestamp_offset_select, 1'h1);
    take;
    axw(`A_DESC0, {7'h15, 8'h09, 1'h1, 1'h0, 4'h1, 11'h00A}, `R_OKAY);
    axw(`A_DESC1, {17'h00300, 15'h0077}, `R_OKAY);
    axw(`A_CTRL, 32'h3, `R_OKAY);
    pop(`EV_CPU_AAL2, 15'h0077);
    check(ev_aal2_li, 11'h008);
    check(ev_cid, 7'h15);
    check(ev_cps_timer, 8'h09);
    check(ev_flush_pending_flag, 1'h1);
    check(ev_timestamp_offset_select, 1'h0);
    take;
    axr(`A_SEQ, 32'h2, `R_OKAY);
    axr(`A_STAT, 32'h4, `R_OKAY);
    axr(`A_DESC2, 32'h0, `R_OKAY);
    axr(12'h100, 32'h0, `R_SLVERR);
    axw(12'h100, 32'h5, `R_SLVERR);
  endtask
  // ===== Clock, reset, run
  initial begin
    clock = 1'h0;
    forever #10 clock = ~clock;
  end
  initial begin
    {rst_n, tmr_valid, tmr_is_sof, tmr_scan_flag, tmr_channel_start_flag, ev_ready} = 6'h0;
    {s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = 5'h0;
    tmr_conn_base = 15'h0;
    tdm_write_ptr = 16'h0;
    frame_timestamp = 16'h0;
    bus_timestamp = 16'h1000;
    s_awaddr = 12'h0;
    s_araddr = 12'h0;
    s_wdata = 32'h0;
    s_wstrb = 4'hF;
    repeat (4) @(posedge clock);
    rst_n <= 1'h1;
    order_fields;
    cpu_inject;
    summarize;
  end
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles > 5000) begin
      mismatches++;
      summarize;
    end
  end
endmodule
`default_nettype wire
